/* core/dsr_pkg.sv */
`default_nettype none

package dsr_pkg;

   localparam int RES_BITS       = 12;
   localparam int FALL_LAST_BIT  = 13;
   localparam int FALL_END       = 32;
   localparam int FALL_PD_LO     = 2;
   localparam int FALL_PD_HI     = 10;
   localparam int FALL_SWAP      = 16;
   localparam int CNT_W          = 6;
   localparam int SYNC_STAGES    = 3;
   localparam int FIFO_DEPTH     = 8;

   typedef enum logic [1:0] {
      DSR_PWR_NORMAL  = 2'b01,
      DSR_PWR_PARTIAL = 2'b10
   } dsr_pwr_t;

   typedef struct packed {
      logic [RES_BITS-1:0] res_a;
      logic [RES_BITS-1:0] res_b;
   } dsr_pair_t;

   typedef struct packed {
      logic data_a;
      logic data_a_oe;
      logic data_b;
      logic data_b_oe;
   } dsr_line_t;

endpackage

`default_nettype wire

/* core/dsr_readout.sv */
`default_nettype none

// ----------------------------------------------------------------
// Result FIFO
// ----------------------------------------------------------------
module dsr_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             do_wr;
   logic             do_rd;

   assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_ptr != rd_ptr;
   assign do_wr       = in_valid_i && in_ready_o;
   assign do_rd       = out_valid_o && out_ready_i;
   assign out_data_o  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk_sys_i) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule // dsr_fifo

// ----------------------------------------------------------------
// Pin synchroniser
// ----------------------------------------------------------------
module dsr_sync #(
   parameter int   STAGES = 3,
   parameter logic IDLE   = 1'b0
) (
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output logic      level_o,
   output logic      fall_o,
   output logic      rise_o
);
   if (STAGES < 3) begin : g_bad_stages
      $error("STAGES must be at least three");
   end

   logic [STAGES-1:0] sync;
   logic              agree;

   assign agree  = sync[STAGES-2] == sync[STAGES-1];
   assign fall_o = level_o && agree && !sync[STAGES-1];
   assign rise_o = !level_o && agree && sync[STAGES-1];

   // Shift the pin through the chain
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sync <= {STAGES{IDLE}};
      end else begin
         sync <= {sync[STAGES-2:0], pin_i};
      end
   end

   // Accept a new level once the last two stages agree
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         level_o <= IDLE;
      end else if (agree) begin
         level_o <= sync[STAGES-1];
      end
   end
endmodule // dsr_sync

// ----------------------------------------------------------------
// Data line shifter
// ----------------------------------------------------------------
module dsr_shift #(
   parameter int RES_BITS = 12,
   parameter int GAP_BITS = 4
) (
   input  wire logic                clk_sys_i,
   input  wire logic                rst_i,
   input  wire logic                load_i,
   input  wire logic                step_i,
   input  wire logic [RES_BITS-1:0] first_i,
   input  wire logic [RES_BITS-1:0] second_i,
   output logic                     bit_o
);
   localparam int LEN = 2 * RES_BITS + GAP_BITS + 2;

   if (RES_BITS < 1 || GAP_BITS < 1) begin : g_bad_shift
      $error("Shifter widths out of range");
   end

   logic [LEN-1:0] image;

   assign bit_o = image[LEN-1];

   // Frame image: two leading zeros, first result, gap, second result
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         image <= '0;
      end else if (load_i) begin
         image <= {2'b00, first_i, {GAP_BITS{1'b0}}, second_i};
      end else if (step_i) begin
         image <= {image[LEN-2:0], 1'b0};
      end
   end
endmodule // dsr_shift

// ----------------------------------------------------------------
// Serial readout
// ----------------------------------------------------------------
module dsr_readout #(
   parameter int DEPTH = dsr_pkg::FIFO_DEPTH
) (
   input  wire logic               clk_sys_i,
   input  wire logic               rst_i,
   input  wire logic               sel_n_i,
   input  wire logic               sclk_i,
   input  wire dsr_pkg::dsr_pair_t conv_i,
   input  wire logic               conv_valid_i,
   output logic                    conv_ready_o,
   output dsr_pkg::dsr_line_t      line_o,
   output logic                    hold_o,
   output dsr_pkg::dsr_pwr_t       pwr_o
);
   import dsr_pkg::*;

   logic                   clk_fall_pin;
   logic                   clk_rise_pin;
   logic                   bit_a;
   logic                   bit_b;
   dsr_pair_t              frame;
   logic                   sel_fall;
   logic                   sel_rise;
   logic                   clk_fall;
   logic                   clk_rise;
   logic [CNT_W-1:0]       falls;
   logic                   active;
   dsr_pair_t              held;
   logic                   fifo_valid;
   logic                   take;
   dsr_pair_t              fifo_data;

   if (DEPTH < 2) begin : g_bad_depth
      $error("DEPTH must be at least two");
   end

   if ((1 << CNT_W) <= FALL_END) begin : g_bad_cnt
      $error("CNT_W too narrow for the frame length");
   end

   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   dsr_sync #(
      .STAGES (SYNC_STAGES),
      .IDLE   (1'b1)
   ) u_sync_sel (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .pin_i     (sel_n_i),
      .level_o   (),
      .fall_o    (sel_fall),
      .rise_o    (sel_rise)
   );

   // Serial clock idles high, so its chain starts high
   dsr_sync #(
      .STAGES (SYNC_STAGES),
      .IDLE   (1'b1)
   ) u_sync_clk (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .pin_i     (sclk_i),
      .level_o   (),
      .fall_o    (clk_fall_pin),
      .rise_o    (clk_rise_pin)
   );

   assign clk_fall = clk_fall_pin && active;
   assign clk_rise = clk_rise_pin && active;

   // ----------------------------------------------------------------
   // Converter results
   // ----------------------------------------------------------------
   dsr_fifo #(
      .WIDTH (2*RES_BITS),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .in_valid_i  (conv_valid_i),
      .in_ready_o  (conv_ready_o),
      .in_data_i   (conv_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (take),
      .out_data_o  (fifo_data)
   );

   assign take = sel_fall && fifo_valid;

   // A fresh result wins; with the FIFO empty the last pair goes again
   assign frame = fifo_valid ? fifo_data : held;

   // ----------------------------------------------------------------
   // Frame sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         active <= 1'b0;
         falls  <= '0;
         held   <= '0;
      end else if (sel_fall) begin
         active <= 1'b1;
         falls  <= '0;
         if (fifo_valid) begin
            held <= fifo_data;
         end
      end else if (sel_rise) begin
         active <= 1'b0;
      end else if (clk_fall && falls != CNT_W'(FALL_END)) begin
         falls <= falls + 1'b1;
      end
   end

   // Track-and-hold: hold from select fall until rise after 13 falls
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         hold_o <= 1'b0;
      end else if (sel_fall) begin
         hold_o <= 1'b1;
      end else if (sel_rise) begin
         hold_o <= 1'b0;
      end else if (clk_rise && falls >= CNT_W'(FALL_LAST_BIT)) begin
         hold_o <= 1'b0;
      end
   end

   // Power-down on abort inside the early window
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pwr_o <= DSR_PWR_NORMAL;
      end else if (sel_rise) begin
         if (falls >= CNT_W'(FALL_PD_LO) && falls < CNT_W'(FALL_PD_HI)) begin
            pwr_o <= DSR_PWR_PARTIAL;
         end
      end else if (sel_fall) begin
         pwr_o <= DSR_PWR_NORMAL;
      end
   end

   // ----------------------------------------------------------------
   // Data lines
   // ----------------------------------------------------------------
   // Frame image: zero, zero, result, zero, zero, zero, zero, other result
   dsr_shift #(
      .RES_BITS (RES_BITS)
   ) u_shift_a (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .load_i    (sel_fall),
      .step_i    (clk_fall),
      .first_i   (frame.res_a),
      .second_i  (frame.res_b),
      .bit_o     (bit_a)
   );

   dsr_shift #(
      .RES_BITS (RES_BITS)
   ) u_shift_b (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .load_i    (sel_fall),
      .step_i    (clk_fall),
      .first_i   (frame.res_b),
      .second_i  (frame.res_a),
      .bit_o     (bit_b)
   );

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         line_o <= '0;
      end else begin
         line_o.data_a    <= sel_fall ? 1'b0 : bit_a;
         line_o.data_b    <= sel_fall ? 1'b0 : bit_b;
         line_o.data_a_oe <= sel_fall || (active && !sel_rise && falls != CNT_W'(FALL_END));
         line_o.data_b_oe <= sel_fall || (active && !sel_rise && falls != CNT_W'(FALL_END));
      end
   end
endmodule // dsr_readout

`default_nettype wire

/* sim/dsr_readout_asserts.sv */
`default_nettype none
// --
// Readout checker
// --
module dsr_readout_asserts (
   input wire logic               clk_sys_i,
   input wire logic               rst_i,
   input wire logic               sel_n_i,
   input wire logic               sclk_i,
   input wire dsr_pkg::dsr_pair_t conv_i,
   input wire logic               conv_valid_i,
   input wire logic               conv_ready_o,
   input wire dsr_pkg::dsr_line_t line_o,
   input wire logic               hold_o,
   input wire dsr_pkg::dsr_pwr_t  pwr_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import dsr_pkg::*;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   wire logic oe = line_o.data_a_oe;
   sequence sel_low8; $fell(sel_n_i) ##1 !sel_n_i [*7]; endsequence
   a_idle_float: assert property (sel_n_i [*8] |-> !oe && !line_o.data_b_oe) else $error("idle drive");
   a_lead_drive: assert property (sel_low8 |-> oe && line_o.data_b_oe) else $error("no drive");
   a_lead_zero: assert property (sel_low8 |-> !line_o.data_a && !line_o.data_b) else $error("lead not zero");
   a_hold_take: assert property (sel_low8 |-> hold_o) else $error("no hold");
   a_oe_cause: assert property ($rose(oe) |-> !sel_n_i && !$past(sel_n_i, 2)) else $error("stray drive");
   a_track_back: assert property ($fell(hold_o) |-> sclk_i || sel_n_i) else $error("early track");
   a_bit_steady: assert property ((sclk_i && !sel_n_i) [*8] |-> $stable(line_o)) else $error("bit moved");
   a_pd_enter: assert property ($rose(pwr_o[1]) |-> sel_n_i) else $error("bad power down");
   a_pd_leave: assert property ($rose(pwr_o[0]) |-> !sel_n_i) else $error("bad wake");
   c_frame: cover property ($rose(oe));
   c_pdown: cover property ($rose(pwr_o[1]));
   c_track: cover property ($fell(hold_o));
endmodule // dsr_readout_asserts
`default_nettype wire

/* sim/dsr_host.sv */
`default_nettype none
// --
// Host serial port model
// --
module dsr_host (
   input  wire dsr_pkg::dsr_line_t line_i,
   output logic                    sel_n_o,
   output logic                    sclk_o,
   output logic [31:0]             cap_a_o,
   output logic [31:0]             cap_b_o,
   output logic [31:0]             cap_r_o,
   output logic                    end_oe_o,
   output logic                    done_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sel_n_o = 1'b1;
      sclk_o = 1'b1;
      done_o = 1'b0;
      end_oe_o = 1'b0;
      cap_a_o = '0;
      cap_b_o = '0;
      cap_r_o = '0;
   end
   // Capture A and B just before each falling edge and R just before each rising edge; a floating line reads unknown
   task automatic frame(input int n);
      sel_n_o = 1'b0;
      repeat (n) begin
         #80;
         cap_a_o = {cap_a_o[30:0], line_i.data_a_oe ? line_i.data_a : 1'bx};
         cap_b_o = {cap_b_o[30:0], line_i.data_b_oe ? line_i.data_b : 1'bx};
         sclk_o = 1'b0;
         #80;
         cap_r_o = {cap_r_o[30:0], line_i.data_a_oe ? line_i.data_a : 1'bx};
         sclk_o = 1'b1;
      end
      #80 end_oe_o = line_i.data_a_oe;
      sel_n_o = 1'b1;
      #100 done_o = 1'b1;
      #4 done_o = 1'b0;
   endtask
endmodule // dsr_host
`default_nettype wire

/* sim/dsr_readout_tb_top.sv */
`default_nettype none
// --
// Readout bench
// --
module dsr_readout_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dsr_pkg::*;
   typedef struct packed {logic [31:0] a, b, m, r, mr; logic oe; dsr_pwr_t pwr;} dsr_note_t;
   logic clk_sys_i = 0, rst_i = 1, conv_valid_i = 0, conv_ready_o, hold_o, sel_n, sclk, end_oe, done;
   dsr_pair_t conv_i = '0;
   dsr_line_t line_o;
   dsr_pwr_t pwr_o;
   logic [31:0] cap_a, cap_b, cap_r;
   int error_cnt = 0, samples_checked = 0, seed = 32'h197f;
   dsr_note_t exp_q[$];
   initial forever #2 clk_sys_i = ~clk_sys_i;
   initial begin #200000; error_cnt++; close_out(); end
   dsr_readout u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sel_n_i(sel_n), .sclk_i(sclk), .conv_i(conv_i),
      .conv_valid_i(conv_valid_i), .conv_ready_o(conv_ready_o), .line_o(line_o), .hold_o(hold_o), .pwr_o(pwr_o));
   dsr_host u_host (.line_i(line_o), .sel_n_o(sel_n), .sclk_o(sclk), .cap_a_o(cap_a), .cap_b_o(cap_b), .cap_r_o(cap_r),
      .end_oe_o(end_oe), .done_o(done));
   task automatic check(input logic [63:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic offer(input dsr_pair_t v);
      int i;
      conv_i = v;
      conv_valid_i = 1'b1;
      for (i = 0; i < 50 && conv_ready_o !== 1'b1; i++) @(posedge clk_sys_i) #1;
      if (i == 50) begin error_cnt++; close_out(); end
      @(posedge clk_sys_i) #1;
   endtask
   function automatic logic [31:0] pat(input logic [11:0] f, s, input int n);
      return {2'b00, f, 4'h0, s, 2'b00} >> (32 - n);
   endfunction
   always @(posedge done) begin
      dsr_note_t e;
      e = '0;
      if (exp_q.size() == 0) error_cnt++;
      else e = exp_q.pop_front();
      check({cap_a & e.m, cap_b & e.m}, {e.a, e.b});
      check(64'(cap_r & e.mr), 64'(e.r & e.mr));
      check(64'(end_oe), 64'(e.oe));
      check(64'(pwr_o), 64'(e.pwr));
      check(64'(hold_o), 64'h0);
   end
   initial begin
      dsr_pair_t p[8];
      dsr_pair_t q;
      dsr_note_t e;
      int k;
      int n;
      int ns[9] = '{32, 14, 16, 1, 5, 20, 9, 32, 32};
      repeat (4) @(posedge clk_sys_i);
      #1 rst_i = 1'b0;
      repeat (4) @(posedge clk_sys_i) #1;
      for (k = 0; k < 8; k++) begin
         p[k] = dsr_pair_t'(24'($random(seed)));
         offer(p[k]);
      end
      conv_i = dsr_pair_t'(24'($random(seed)));
      repeat (2) @(posedge clk_sys_i) #1;
      check(64'(conv_ready_o), 64'h0);
      conv_valid_i = 1'b0;
      for (k = 0; k < 9; k++) begin
         n = ns[k];
         q = p[k < 8 ? k : 7];
         e.a = pat(q.res_a, q.res_b, n);
         e.b = pat(q.res_b, q.res_a, n);
         e.m = n == 32 ? 32'hFFFF_FFFC : (32'h0000_0001 << n) - 32'h0000_0001;
         e.r = n == 32 ? pat(q.res_a, q.res_b, 32) << 1 : pat(q.res_a, q.res_b, n + 1);
         e.mr = n == 32 ? 32'hFFFF_FFFE : e.m;
         e.oe = n < 32;
         e.pwr = n >= 2 && n < 10 ? DSR_PWR_PARTIAL : DSR_PWR_NORMAL;
         exp_q.push_back(e);
         u_host.frame(n);
      end
      check(64'(exp_q.size()), 64'h0);
      close_out();
   end
endmodule // dsr_readout_tb_top
bind dsr_readout dsr_readout_asserts u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sel_n_i(sel_n_i),
   .sclk_i(sclk_i), .conv_i(conv_i), .conv_valid_i(conv_valid_i), .conv_ready_o(conv_ready_o),
   .line_o(line_o), .hold_o(hold_o), .pwr_o(pwr_o));
`default_nettype wire
